//--- design/pcibr_dev.sv
`timescale 1ns/1ns
module pcibr_dev
	import pcibr_pkg::*;
#(
	parameter logic [31:0] TGT_BASE = 32'h00010000,
	parameter logic [31:0] TGT_MASK = 32'hFFFFFFF0,
	parameter logic [31:0] SUB_DATA = 32'hFFFFFFFF
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic power_good_reset_in_n,
	input wire logic serr_enable,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [31:0] req_addr,
	input wire logic [31:0] req_wdata,
	input wire logic [3:0] req_be,
	output logic req_busy,
	output logic resp_valid,
	output logic [1:0] resp_status,
	output logic [31:0] resp_rdata,
	output logic nmi,
	output logic [3:0] irq_n,
	pcibr_if.dev pci
);
	typedef struct packed {
		logic [3:0] pdiv;
		logic pclk;
		logic [4:0] rcnt;
		logic sro_n;
		logic pg1;
		logic pg2;
		logic ck1;
		logic ck2;
		logic ck3;
		pcibr_bus_s b1;
		pcibr_bus_s b2;
		logic [2:0] rq1;
		logic [2:0] rq2;
		logic [3:0] ia1;
		logic [3:0] ia2;
		logic fprev;
		pcibr_bus_s o;
		pcibr_oe_s oe;
		logic [2:0] gnt_n;
		logic gdev;
		logic [1:0] last;
		pcibr_ist_e ist;
		logic [2:0] icnt;
		logic [31:0] iaddr;
		logic [31:0] iwdat;
		logic [3:0] ibe;
		logic iwr;
		logic busy;
		logic rv;
		logic [1:0] rst;
		logic [31:0] rdat;
		logic sen;
		logic nmi;
		logic [3:0] irq;
		pcibr_tst_e tst;
		logic [2:0] tcnt;
		logic [1:0] tidx;
		logic twr;
		logic tsub;
		logic tret;
		logic locked;
		logic [3:0][31:0] mem;
	} pcibr_dev_s;

	pcibr_dev_s s_r;
	pcibr_dev_s s_nxt;
	pcibr_bus_s b;
	logic tk;
	logic want;
	logic hold;
	logic gv;
	logic [1:0] gi;
	logic [1:0] j;
	logic [3:0] reqv;

	// next state of the whole block
	always_comb
	begin
		s_nxt = s_r;
		b = s_r.b2;
		tk = s_r.ck2 & ~s_r.ck3; // rising edge of the fed-back bus clock
		want = s_r.busy && (s_r.ist == I_IDLE);
		reqv = {want, ~s_r.rq2};
		hold = (s_r.gdev && want) || (|(~s_r.gnt_n & ~s_r.rq2));
		gv = 1'b0;
		gi = 2'h0;
		j = 2'h0;
		s_nxt.rv = 1'b0;
		// bus clock divider driven out
		s_nxt.pdiv = (s_r.pdiv == PDIV_MAX) ? 4'h0 : s_r.pdiv + 4'h1;
		if (s_r.pdiv == 4'h0)
			s_nxt.pclk = 1'b1;
		else if (s_r.pdiv == PDIV_HALF)
			s_nxt.pclk = 1'b0;
		// synchronisers for everything from outside
		s_nxt.pg1 = power_good_reset_in_n;
		s_nxt.pg2 = s_r.pg1;
		s_nxt.ck1 = pci.pci_clock_in;
		s_nxt.ck2 = s_r.ck1;
		s_nxt.ck3 = s_r.ck2;
		s_nxt.b1 = pci.bus;
		s_nxt.b2 = s_r.b1;
		s_nxt.rq1 = pci.ext_master_request_n;
		s_nxt.rq2 = s_r.rq1;
		s_nxt.ia1 = pci.inta_n;
		s_nxt.ia2 = s_r.ia1;
		// reset output held low, then stretched from the power-good rise
		if (!s_r.pg2)
			s_nxt.rcnt = RST_STRETCH;
		else if (s_r.rcnt != 5'h0)
			s_nxt.rcnt = s_r.rcnt - 5'h1;
		s_nxt.sro_n = s_r.pg2 && (s_r.rcnt == 5'h0);
		s_nxt.sen = serr_enable;
		s_nxt.nmi = ~b.serr_n;
		s_nxt.irq = s_r.ia2;
		// host cycle capture
		if (req_valid && !s_r.busy)
		begin
			s_nxt.busy = 1'b1;
			s_nxt.iaddr = req_addr;
			s_nxt.iwdat = req_wdata;
			s_nxt.ibe = req_be;
			s_nxt.iwr = req_write;
		end
		if (tk)
		begin
			s_nxt.fprev = b.frame_n;
			// parity trails the lines it covers by one bus clock
			// command lines may belong to the other agent, so take them from the bus
			s_nxt.o.par = ^{s_r.o.ad, b.cbe};
			s_nxt.oe.par = s_r.oe.ad;
			// error pulse lasts one bus clock
			if (s_r.oe.serr)
			begin
				s_nxt.oe.serr = 1'b0;
				s_nxt.o.serr_n = 1'b1;
			end
			// arbiter: re-decide only on an idle bus when the holder let go
			if (b.frame_n && b.irdy_n && (s_r.ist == I_IDLE) && !hold)
			begin
				for (int k = 1; k <= 4; k++)
				begin
					j = 2'(s_r.last + k[1:0]);
					if (!gv && reqv[j])
					begin
						gv = 1'b1;
						gi = j;
					end
				end
				s_nxt.gnt_n = 3'h7;
				s_nxt.gdev = 1'b0;
				if (gv)
				begin
					s_nxt.last = gi;
					if (gi == 2'h3)
						s_nxt.gdev = 1'b1;
					else
						s_nxt.gnt_n[gi] = 1'b0;
				end
			end
			// initiator
			case (s_r.ist)
				I_IDLE:
					if (s_r.busy && s_r.gdev && b.frame_n && b.irdy_n && s_r.tst == T_IDLE)
					begin
						s_nxt.o.frame_n = 1'b0;
						s_nxt.o.irdy_n = 1'b1;
						s_nxt.o.lock_n = 1'b1;
						s_nxt.o.ad = s_r.iaddr;
						s_nxt.o.cbe = s_r.iwr ? CMD_MEM_WR : CMD_MEM_RD;
						s_nxt.oe.ad = 1'b1;
						s_nxt.oe.cbe = 1'b1;
						s_nxt.oe.mst = 1'b1;
						s_nxt.ist = I_ADDR;
					end
				I_ADDR:
				begin
					s_nxt.o.frame_n = 1'b1;
					s_nxt.o.irdy_n = 1'b0;
					s_nxt.o.cbe = s_r.ibe;
					s_nxt.o.ad = s_r.iwdat;
					s_nxt.oe.ad = s_r.iwr;
					s_nxt.icnt = 3'h0;
					s_nxt.ist = I_DATA;
				end
				I_DATA:
				begin
					s_nxt.icnt = s_r.icnt + 3'h1;
					if (!b.trdy_n)
					begin
						s_nxt.rst = ST_OK;
						s_nxt.rdat = b.ad;
						s_nxt.ist = I_TURN;
					end
					else if (!b.stop_n)
					begin
						s_nxt.rst = b.devsel_n ? ST_TABORT : ST_RETRY;
						s_nxt.ist = I_TURN;
						if (b.devsel_n && s_r.sen)
						begin
							s_nxt.o.serr_n = 1'b0;
							s_nxt.oe.serr = 1'b1;
						end
					end
					else if (b.devsel_n && s_r.icnt == MABORT_CLKS)
					begin
						s_nxt.rst = ST_MABORT;
						s_nxt.ist = I_TURN;
					end
					if (s_nxt.ist == I_TURN)
					begin
						s_nxt.o.irdy_n = 1'b1;
						s_nxt.oe.ad = 1'b0;
					end
				end
				default:
				begin
					s_nxt.oe.mst = 1'b0;
					s_nxt.oe.cbe = 1'b0;
					s_nxt.busy = 1'b0;
					s_nxt.rv = 1'b1;
					s_nxt.ist = I_IDLE;
				end
			endcase
			// target with positive and subtractive decode
			case (s_r.tst)
				T_IDLE:
					if (!b.frame_n && s_r.fprev && !s_r.oe.mst)
					begin
						s_nxt.tidx = b.ad[3:2];
						s_nxt.twr = (b.cbe == CMD_MEM_WR);
						s_nxt.tret = s_r.locked && b.lock_n;
						s_nxt.tcnt = 3'h0;
						s_nxt.tsub = !((b.ad & TGT_MASK) == TGT_BASE
							&& (b.cbe == CMD_MEM_WR || b.cbe == CMD_MEM_RD));
						s_nxt.tst = T_WAIT;
					end
				T_WAIT:
				begin
					s_nxt.tcnt = s_r.tcnt + 3'h1;
					if (s_r.tsub && !b.devsel_n)
						s_nxt.tst = T_IDLE;
					else if (!s_r.tsub || s_r.tcnt == SUBTR_CLKS - 3'h1)
					begin
						s_nxt.o.devsel_n = 1'b0;
						s_nxt.o.trdy_n = s_r.tret;
						s_nxt.o.stop_n = !(s_r.tret || !b.frame_n);
						s_nxt.o.ad = s_r.tsub ? SUB_DATA : s_r.mem[s_r.tidx];
						s_nxt.oe.ad = !s_r.twr;
						s_nxt.oe.tgt = 1'b1;
						s_nxt.tst = T_DATA;
					end
				end
				T_DATA:
					if ((s_r.tret && b.frame_n) || (!s_r.tret && !b.irdy_n))
					begin
						if (!s_r.tret && s_r.twr && !s_r.tsub)
							for (int k = 0; k < 4; k++)
								if (!b.cbe[k])
									s_nxt.mem[s_r.tidx][8*k +: 8] = b.ad[8*k +: 8];
						if (!s_r.tret && !b.lock_n)
							s_nxt.locked = 1'b1;
						s_nxt.o.devsel_n = 1'b1;
						s_nxt.o.trdy_n = 1'b1;
						s_nxt.o.stop_n = 1'b1;
						s_nxt.oe.ad = 1'b0;
						s_nxt.tst = T_TURN;
					end
				default:
				begin
					s_nxt.oe.tgt = 1'b0;
					s_nxt.tst = T_IDLE;
				end
			endcase
			// lock released once frame and lock are both idle
			if (s_r.locked && b.frame_n && b.lock_n && s_r.tst != T_DATA)
				s_nxt.locked = 1'b0;
		end
		if (!rst_n)
		begin
			s_nxt = '0;
			s_nxt.rcnt = RST_STRETCH;
			s_nxt.b1 = '1;
			s_nxt.b2 = '1;
			s_nxt.rq1 = 3'h7;
			s_nxt.rq2 = 3'h7;
			s_nxt.ia1 = 4'hF;
			s_nxt.ia2 = 4'hF;
			s_nxt.irq = 4'hF;
		end
		if (!rst_n || !s_r.sro_n)
		begin
			s_nxt.o = '1;
			s_nxt.oe = '0;
			s_nxt.gnt_n = 3'h7;
			s_nxt.gdev = 1'b0;
			s_nxt.ist = I_IDLE;
			s_nxt.tst = T_IDLE;
			s_nxt.locked = 1'b0;
			s_nxt.fprev = 1'b1;
			s_nxt.busy = 1'b0;
			s_nxt.rv = 1'b0;
			s_nxt.sen = 1'b0;
		end
	end

	// single state register
	always_ff @(posedge clk)
	begin
		s_r <= s_nxt;
	end

	assign pci.pci_clock_out = s_r.pclk;
	assign pci.system_reset_out_n = s_r.sro_n;
	assign pci.dev_o = s_r.o;
	assign pci.dev_oe = s_r.oe;
	assign pci.ext_master_grant_n = s_r.gnt_n;
	assign req_busy = s_r.busy;
	assign resp_valid = s_r.rv;
	assign resp_status = s_r.rst;
	assign resp_rdata = s_r.rdat;
	assign nmi = s_r.nmi;
	assign irq_n = s_r.irq;
endmodule : pcibr_dev

//--- design/pcibr_host.sv
`timescale 1ns/1ns
module pcibr_host
	import pcibr_pkg::*;
#(
	parameter logic [31:0] HOST_BASE = 32'h00020000,
	parameter logic [31:0] HOST_MASK = 32'hFFFFFFFC
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic m_valid,
	input wire logic m_write,
	input wire logic m_lock,
	input wire logic [31:0] m_addr,
	input wire logic [31:0] m_wdata,
	input wire logic [1:0] spare_req_n,
	input wire logic [3:0] irq_in_n,
	input wire logic t_abort,
	output logic m_busy,
	output logic m_done,
	output logic [1:0] m_status,
	output logic [31:0] m_rdata,
	output logic [31:0] t_data,
	pcibr_if.hst pci
);
	typedef struct packed {
		logic ck1;
		logic ck2;
		logic ck3;
		logic rs1;
		logic rs2;
		pcibr_bus_s b1;
		pcibr_bus_s b2;
		logic [2:0] g1;
		logic [2:0] g2;
		logic fprev;
		pcibr_bus_s o;
		pcibr_oe_s oe;
		logic [2:0] rq;
		logic [3:0] irq;
		pcibr_ist_e ist;
		logic [2:0] icnt;
		logic [31:0] addr;
		logic [31:0] wdat;
		logic wr;
		logic lk;
		logic busy;
		logic done;
		logic [1:0] st;
		logic [31:0] rdat;
		pcibr_tst_e tst;
		logic twr;
		logic tab;
		logic [31:0] treg;
	} pcibr_host_s;

	pcibr_host_s s_r;
	pcibr_host_s s_nxt;
	pcibr_bus_s b;
	logic tk;

	// next state of the far end
	always_comb
	begin
		s_nxt = s_r;
		b = s_r.b2;
		tk = s_r.ck2 & ~s_r.ck3;
		s_nxt.done = 1'b0;
		s_nxt.ck1 = pci.pci_clock_in;
		s_nxt.ck2 = s_r.ck1;
		s_nxt.ck3 = s_r.ck2;
		s_nxt.rs1 = pci.pci_rst_n;
		s_nxt.rs2 = s_r.rs1;
		s_nxt.b1 = pci.bus;
		s_nxt.b2 = s_r.b1;
		s_nxt.g1 = pci.ext_master_grant_n;
		s_nxt.g2 = s_r.g1;
		s_nxt.irq = irq_in_n;
		s_nxt.rq = {spare_req_n, !(s_r.busy && s_r.ist == I_IDLE)};
		if (m_valid && !s_r.busy)
		begin
			s_nxt.busy = 1'b1;
			s_nxt.addr = m_addr;
			s_nxt.wdat = m_wdata;
			s_nxt.wr = m_write;
			s_nxt.lk = m_lock;
		end
		if (tk)
		begin
			s_nxt.fprev = b.frame_n;
			s_nxt.o.par = ^{s_r.o.ad, b.cbe};
			s_nxt.oe.par = s_r.oe.ad;
			// master on slot zero
			case (s_r.ist)
				I_IDLE:
					if (s_r.busy && !s_r.g2[0] && b.frame_n && b.irdy_n)
					begin
						s_nxt.o.frame_n = 1'b0;
						s_nxt.o.irdy_n = 1'b1;
						s_nxt.o.lock_n = !s_r.lk;
						s_nxt.o.ad = s_r.addr;
						s_nxt.o.cbe = s_r.wr ? CMD_MEM_WR : CMD_MEM_RD;
						s_nxt.oe.ad = 1'b1;
						s_nxt.oe.cbe = 1'b1;
						s_nxt.oe.mst = 1'b1;
						s_nxt.ist = I_ADDR;
					end
				I_ADDR:
				begin
					s_nxt.o.frame_n = 1'b1;
					s_nxt.o.irdy_n = 1'b0;
					s_nxt.o.cbe = 4'h0;
					s_nxt.o.ad = s_r.wdat;
					s_nxt.oe.ad = s_r.wr;
					s_nxt.icnt = 3'h0;
					s_nxt.ist = I_DATA;
				end
				I_DATA:
				begin
					s_nxt.icnt = s_r.icnt + 3'h1;
					if (!b.trdy_n || !b.stop_n || (b.devsel_n && s_r.icnt == MABORT_CLKS))
					begin
						s_nxt.st = !b.trdy_n ? ST_OK : !b.stop_n ?
							(b.devsel_n ? ST_TABORT : ST_RETRY) : ST_MABORT;
						s_nxt.rdat = b.ad;
						s_nxt.o.irdy_n = 1'b1;
						s_nxt.o.lock_n = 1'b1;
						s_nxt.oe.ad = 1'b0;
						s_nxt.ist = I_TURN;
					end
				end
				default:
				begin
					s_nxt.oe.mst = 1'b0;
					s_nxt.oe.cbe = 1'b0;
					s_nxt.busy = 1'b0;
					s_nxt.done = 1'b1;
					s_nxt.ist = I_IDLE;
				end
			endcase
			// one-word target with fast decode, byte enables ignored
			case (s_r.tst)
				T_IDLE:
					if (!b.frame_n && s_r.fprev && !s_r.oe.mst
						&& (b.ad & HOST_MASK) == HOST_BASE)
					begin
						s_nxt.twr = (b.cbe == CMD_MEM_WR);
						s_nxt.tab = t_abort;
						s_nxt.o.devsel_n = t_abort;
						s_nxt.o.trdy_n = t_abort;
						s_nxt.o.stop_n = !t_abort;
						s_nxt.o.ad = s_r.treg;
						s_nxt.oe.ad = (b.cbe != CMD_MEM_WR);
						s_nxt.oe.tgt = 1'b1;
						s_nxt.tst = T_DATA;
					end
				T_DATA:
					if ((s_r.tab && b.frame_n && b.irdy_n) || (!s_r.tab && !b.irdy_n))
					begin
						if (!s_r.tab && s_r.twr)
							s_nxt.treg = b.ad;
						s_nxt.o.devsel_n = 1'b1;
						s_nxt.o.trdy_n = 1'b1;
						s_nxt.o.stop_n = 1'b1;
						s_nxt.oe.ad = 1'b0;
						s_nxt.tst = T_TURN;
					end
				default:
				begin
					s_nxt.oe.tgt = 1'b0;
					s_nxt.tst = T_IDLE;
				end
			endcase
		end
		if (!rst_n || !s_r.rs2)
		begin
			s_nxt.o = '1;
			s_nxt.oe = '0;
			s_nxt.ist = I_IDLE;
			s_nxt.tst = T_IDLE;
			s_nxt.busy = 1'b0;
			s_nxt.done = 1'b0;
			s_nxt.fprev = 1'b1;
			s_nxt.rq = 3'h7;
		end
		if (!rst_n)
		begin
			s_nxt.ck1 = 1'b0;
			s_nxt.ck2 = 1'b0;
			s_nxt.ck3 = 1'b0;
			s_nxt.rs1 = 1'b0;
			s_nxt.rs2 = 1'b0;
			s_nxt.b1 = '1;
			s_nxt.b2 = '1;
			s_nxt.g1 = 3'h7;
			s_nxt.g2 = 3'h7;
			s_nxt.irq = 4'hF;
			s_nxt.icnt = 3'h0;
			s_nxt.st = ST_OK;
			s_nxt.rdat = 32'h00000000;
			s_nxt.treg = 32'h00000000;
		end
	end

	// single state register
	always_ff @(posedge clk)
	begin
		s_r <= s_nxt;
	end

	assign pci.hst_o = s_r.o;
	assign pci.hst_oe = s_r.oe;
	assign pci.ext_master_request_n = s_r.rq;
	assign pci.inta_n = s_r.irq;
	assign m_busy = s_r.busy;
	assign m_done = s_r.done;
	assign m_status = s_r.st;
	assign m_rdata = s_r.rdat;
	assign t_data = s_r.treg;
endmodule : pcibr_host

//--- design/pcibr_if.sv
`timescale 1ns/1ns
interface pcibr_if import pcibr_pkg::*; ();
	logic pci_clock_out;
	logic pci_clock_in;
	logic system_reset_out_n;
	logic pci_rst_n;
	pcibr_bus_s dev_o;
	pcibr_oe_s dev_oe;
	pcibr_bus_s hst_o;
	pcibr_oe_s hst_oe;
	pcibr_bus_s bus;
	logic [2:0] ext_master_request_n;
	logic [2:0] ext_master_grant_n;
	logic [3:0] inta_n;

	// board feedback of the bus clock and buffered bus reset
	assign pci_clock_in = pci_clock_out;
	assign pci_rst_n = system_reset_out_n;
	assign bus = pcibr_wire(dev_o, dev_oe, hst_o, hst_oe);

	modport dev(output pci_clock_out, output system_reset_out_n, output dev_o, output dev_oe,
		output ext_master_grant_n, input pci_clock_in, input bus, input ext_master_request_n,
		input inta_n);
	modport hst(output hst_o, output hst_oe, output ext_master_request_n, output inta_n,
		input pci_clock_in, input pci_rst_n, input bus, input ext_master_grant_n);
endinterface : pcibr_if

//--- design/pcibr_pkg.sv
// What this block does
// - drive bus clock out, run from feedback
// - hard reset held while power bad, stretched past power-good rise
// - bus reset buffers system reset output
// - initiator drives address/write data, target read
// - command/enables driven only while owning bus
// - frame driven when owner, sampled otherwise
// - drive initiator-ready as master, sample as target
// - drive target-ready as target, sample as master
// - target honours exclusive lock sequences
// - claim positively or by subtractive decode
// - initiator samples device-select for a claim
// - stop drives as target, sampled as master
// - even parity over data, command and parity
// - read parity one bus clock after data
// - enabled error pulse on target abort
// - any system error raises host NMI
// - three requests in, matching grants out
// - external master waits for own grant
// - four bus interrupt inputs passed on
package pcibr_pkg;
	localparam int PCI_MHZ = 33;
	localparam int CLK_MHZ = 250;
	// bus clock period in system cycles, rounded up so the bus never runs fast
	localparam int PCI_DIV = (CLK_MHZ + PCI_MHZ - 1) / PCI_MHZ;
	localparam logic [3:0] PDIV_MAX = 4'(PCI_DIV - 1);
	localparam logic [3:0] PDIV_HALF = 4'(PCI_DIV / 2);
	localparam logic [4:0] RST_STRETCH = 5'h10;
	localparam logic [2:0] SUBTR_CLKS = 3'h3;
	localparam logic [2:0] MABORT_CLKS = 3'h5;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [1:0] ST_OK = 2'h0;
	localparam logic [1:0] ST_MABORT = 2'h1;
	localparam logic [1:0] ST_TABORT = 2'h2;
	localparam logic [1:0] ST_RETRY = 2'h3;

	typedef enum logic [3:0] {I_IDLE = 4'h1, I_ADDR = 4'h2, I_DATA = 4'h4, I_TURN = 4'h8}
		pcibr_ist_e;
	typedef enum logic [3:0] {T_IDLE = 4'h1, T_WAIT = 4'h2, T_DATA = 4'h4, T_TURN = 4'h8}
		pcibr_tst_e;

	typedef struct packed {
		logic [31:0] ad;
		logic [3:0] cbe;
		logic par;
		logic frame_n;
		logic irdy_n;
		logic lock_n;
		logic trdy_n;
		logic devsel_n;
		logic stop_n;
		logic serr_n;
	} pcibr_bus_s;

	// mst covers frame, initiator-ready, lock; tgt covers target-ready, select, stop
	typedef struct packed {
		logic ad;
		logic cbe;
		logic par;
		logic mst;
		logic tgt;
		logic serr;
	} pcibr_oe_s;

	// board wiring: pull-ups where nobody drives, error line open drain
	function automatic pcibr_bus_s pcibr_wire(input pcibr_bus_s d, input pcibr_oe_s de,
		input pcibr_bus_s h, input pcibr_oe_s he);
		pcibr_bus_s w;
		w = '1;
		if (de.ad) w.ad = d.ad; else if (he.ad) w.ad = h.ad;
		if (de.cbe) w.cbe = d.cbe; else if (he.cbe) w.cbe = h.cbe;
		if (de.par) w.par = d.par; else if (he.par) w.par = h.par;
		if (de.mst) {w.frame_n, w.irdy_n, w.lock_n} = {d.frame_n, d.irdy_n, d.lock_n};
		else if (he.mst) {w.frame_n, w.irdy_n, w.lock_n} = {h.frame_n, h.irdy_n, h.lock_n};
		if (de.tgt) {w.trdy_n, w.devsel_n, w.stop_n} = {d.trdy_n, d.devsel_n, d.stop_n};
		else if (he.tgt) {w.trdy_n, w.devsel_n, w.stop_n} = {h.trdy_n, h.devsel_n, h.stop_n};
		w.serr_n = ~((de.serr & ~d.serr_n) | (he.serr & ~h.serr_n));
		return w;
	endfunction : pcibr_wire
endpackage : pcibr_pkg

//--- sim/pci_host_master_target_arbiter_test.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
	begin \
		cmp_count++; \
		if ((got) !== (ex)) \
		begin \
			miscompares++; \
			$display("MISMATCH %s expected %0h seen %0h", nm, ex, got); \
		end \
	end
module pci_host_master_target_arbiter_test import pcibr_pkg::*;;
	localparam logic [31:0] HOST_ADDR = 32'h00020000;
	localparam logic [31:0] TGT_ADDR = 32'h00010000;
	localparam logic [31:0] SUB_WORD = 32'hFFFFFFFF;
	logic clk = 1'b0, rst_n = 1'b0, pg_n = 1'b0;
	logic serr_en, req_valid, req_write, req_busy, resp_valid, nmi, nmi_seen;
	logic [31:0] req_addr, req_wdata, resp_rdata, m_addr, m_wdata, m_rdata, t_data, seed;
	logic [3:0] req_be, irq_n, irq_in_n;
	logic [1:0] resp_status, m_status, spare_req_n;
	logic m_valid, m_write, m_lock, t_abort, m_busy, m_done;
	logic [34:0] dev_q[$], hst_q[$];
	logic [31:0] w[4];
	int miscompares = 0, cmp_count = 0, i, n;

	pcibr_if pcibr_if_inst ();
	pcibr_dev #(.TGT_BASE(TGT_ADDR), .TGT_MASK(32'hFFFFFFF0), .SUB_DATA(SUB_WORD)) pcibr_dev_inst (
		.clk(clk), .rst_n(rst_n), .power_good_reset_in_n(pg_n), .serr_enable(serr_en),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_be(req_be), .req_busy(req_busy), .resp_valid(resp_valid), .resp_status(resp_status),
		.resp_rdata(resp_rdata), .nmi(nmi), .irq_n(irq_n), .pci(pcibr_if_inst.dev));
	pcibr_host #(.HOST_BASE(HOST_ADDR), .HOST_MASK(32'hFFFFFFFC)) pcibr_host_inst (
		.clk(clk), .rst_n(rst_n), .m_valid(m_valid), .m_write(m_write), .m_lock(m_lock),
		.m_addr(m_addr), .m_wdata(m_wdata), .spare_req_n(spare_req_n), .irq_in_n(irq_in_n),
		.t_abort(t_abort), .m_busy(m_busy), .m_done(m_done), .m_status(m_status),
		.m_rdata(m_rdata), .t_data(t_data), .pci(pcibr_if_inst.hst));
	pcibr_checker pcibr_checker_inst (.clk(clk), .rst_n(rst_n),
		.pci_clock_in(pcibr_if_inst.pci_clock_in),
		.system_reset_out_n(pcibr_if_inst.system_reset_out_n), .bus(pcibr_if_inst.bus),
		.dev_oe(pcibr_if_inst.dev_oe), .hst_oe(pcibr_if_inst.hst_oe),
		.ext_master_request_n(pcibr_if_inst.ext_master_request_n),
		.ext_master_grant_n(pcibr_if_inst.ext_master_grant_n));

	// system clock
	always #2 clk = ~clk;

	// verdict and end of run
	task automatic test_done();
		if (miscompares == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done

	// a used-up wait counts as a mismatch
	task automatic bounded(input int k, input int lim);
		if (k >= lim)
		begin
			miscompares++;
			test_done();
		end
	endtask : bounded

	// oldest note against a completion
	task automatic chk_pop(ref logic [34:0] q[$], input logic [1:0] st, input logic [31:0] rd,
		input string nm);
		logic [34:0] e;
		e = (q.size() != 0) ? q.pop_front() : 35'h7FFFFFFFF;
		`CHK(nm, e, {e[34], st, e[34] ? rd : e[31:0]})
	endtask : chk_pop

	// completion watcher, looks at settled outputs
	always @(negedge clk)
	begin
		if (resp_valid === 1'b1)
			chk_pop(dev_q, resp_status, resp_rdata, "device response");
		if (m_done === 1'b1)
			chk_pop(hst_q, m_status, m_rdata, "host response");
		if (nmi === 1'b1)
			nmi_seen = 1'b1;
	end

	// one request from either end, note pushed, wait for its completion
	task automatic xfer(input logic host, wr, lk, input logic [31:0] a, d,
		input logic [34:0] e);
		int k;
		if (host)
			hst_q.push_back(e);
		else
			dev_q.push_back(e);
		{m_write, m_lock, m_addr, m_wdata} = {wr, lk, a, d};
		{req_write, req_addr, req_wdata} = {wr, a, d};
		req_be = 4'($urandom);
		m_valid = host;
		req_valid = !host;
		@(negedge clk);
		m_valid = 1'b0;
		req_valid = 1'b0;
		`CHK("busy after take", 1'b1, host ? m_busy : req_busy)
		for (k = 0; k < 4000 && dev_q.size() + hst_q.size() != 0; k++)
			@(negedge clk);
		bounded(k, 4000);
	endtask : xfer

	// main sequence
	initial
	begin
		{serr_en, req_valid, req_write, m_valid, m_write, m_lock, t_abort} = '0;
		{req_addr, req_wdata, m_addr, m_wdata} = '0;
		req_be = 4'h0;
		spare_req_n = 2'h3;
		irq_in_n = 4'hF;
		nmi_seen = 1'b0;
		seed = $urandom(32'hD5870695);
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (8) @(negedge clk);
		`CHK("reset out while power bad", 1'b0, pcibr_if_inst.system_reset_out_n)
		pg_n = 1'b1;
		for (n = 0; n < 200 && pcibr_if_inst.system_reset_out_n !== 1'b1; n++)
			@(negedge clk);
		bounded(n, 200);
		`CHK("reset stretch", 1'b1, n >= 16)
		w[0] = $urandom;
		xfer(0, 1, 0, HOST_ADDR, w[0], {1'b0, ST_OK, 32'h0});
		`CHK("host target word", w[0], t_data)
		xfer(0, 0, 0, HOST_ADDR, 32'h0, {1'b1, ST_OK, w[0]});
		xfer(0, 0, 0, 32'h00030000, 32'h0, {1'b0, ST_MABORT, 32'h0});
		t_abort = 1'b1;
		for (i = 0; i < 2; i++)
		begin
			serr_en = ~i[0];
			nmi_seen = 1'b0;
			xfer(0, 0, 0, HOST_ADDR, 32'h0, {1'b0, ST_TABORT, 32'h0});
			repeat (40) @(negedge clk);
			`CHK("nmi raised", ~i[0], nmi_seen)
		end
		t_abort = 1'b0;
		for (i = 0; i < 4; i++)
		begin
			w[i] = $urandom;
			xfer(1, 1, 0, TGT_ADDR + 32'(4 * i), w[i], {1'b0, ST_OK, 32'h0});
		end
		for (i = 0; i < 4; i++)
			xfer(1, 0, 0, TGT_ADDR + 32'(4 * i), 32'h0, {1'b1, ST_OK, w[i]});
		xfer(1, 1, 0, 32'h00050000, w[0], {1'b0, ST_OK, 32'h0});
		xfer(1, 0, 0, 32'h00050000, 32'h0, {1'b1, ST_OK, SUB_WORD});
		xfer(1, 1, 1, TGT_ADDR, w[1], {1'b0, ST_OK, 32'h0});
		xfer(1, 0, 0, TGT_ADDR, 32'h0, {1'b1, ST_OK, w[1]});
		irq_in_n = 4'($urandom);
		repeat (20) @(negedge clk);
		`CHK("interrupt lines", irq_in_n, irq_n)
		spare_req_n = 2'h1;
		for (n = 0; n < 200 && pcibr_if_inst.ext_master_grant_n === 3'h7; n++)
			@(negedge clk);
		bounded(n, 200);
		`CHK("grant to line 2", 3'h3, pcibr_if_inst.ext_master_grant_n)
		spare_req_n = 2'h3;
		repeat (20) @(negedge clk);
		test_done();
	end
endmodule : pci_host_master_target_arbiter_test

//--- sim/pcibr_checker.sv
`timescale 1ns/1ns
// watches the bus joining both ends
module pcibr_checker
	import pcibr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pci_clock_in,
	input wire logic system_reset_out_n,
	input wire pcibr_bus_s bus,
	input wire pcibr_oe_s dev_oe,
	input wire pcibr_oe_s hst_oe,
	input wire logic [2:0] ext_master_request_n,
	input wire logic [2:0] ext_master_grant_n
);
	logic [35:0] prev_r;
	logic prev_drv_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// lines seen in the previous bus clock
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			prev_r <= '0;
			prev_drv_r <= 1'b0;
		end
		else if ($rose(pci_clock_in))
		begin
			prev_r <= {bus.ad, bus.cbe};
			prev_drv_r <= dev_oe.ad | hst_oe.ad;
		end
	end

	AST_BUS_CLK_PERIOD: assert property (
		$rose(pci_clock_in) |=> (!$rose(pci_clock_in)) [*7] ##1 $rose(pci_clock_in))
		else $error("bus clock period wrong");
	AST_RESET_QUIET: assert property (
		!system_reset_out_n |-> ext_master_grant_n == 3'h7 && !dev_oe.mst && !dev_oe.ad)
		else $error("bus activity during reset output");
	AST_AD_ONE_DRIVER: assert property (!(dev_oe.ad && hst_oe.ad))
		else $error("two drivers on address/data");
	AST_CBE_WITH_OWNERSHIP: assert property (dev_oe.cbe |-> dev_oe.mst)
		else $error("command lines driven without ownership");
	AST_FRAME_ONE_OWNER: assert property (!(dev_oe.mst && hst_oe.mst))
		else $error("two owners of frame");
	AST_TARGET_ONE_DRIVER: assert property (!(dev_oe.tgt && hst_oe.tgt))
		else $error("two targets drive ready");
	AST_EVEN_PARITY: assert property (
		$rose(pci_clock_in) && prev_drv_r && (dev_oe.par || hst_oe.par)
		|-> ^{prev_r, bus.par} == 1'b0)
		else $error("parity not even one bus clock later");
	AST_ERROR_ONE_BUS_CLOCK: assert property (
		$fell(bus.serr_n) |-> (!bus.serr_n) [*8] ##1 bus.serr_n)
		else $error("system error pulse not one bus clock");
	AST_GRANT_AT_MOST_ONE: assert property ($countones(~ext_master_grant_n) <= 1)
		else $error("more than one grant");
	AST_GRANT_AFTER_REQUEST: assert property (
		$fell(ext_master_grant_n[0]) |-> $past(ext_master_request_n[0], 2) == 1'b0)
		else $error("grant without request");

	// main scenarios reached
	cover property ($fell(bus.serr_n));
	cover property ($fell(ext_master_grant_n[0]));
	cover property ($fell(ext_master_grant_n[2]));
	cover property ($rose(dev_oe.tgt));
endmodule : pcibr_checker
